// ### hw/dpmc_defs.svh
// address map, field positions and encodings of the profile mode control
`ifndef DPMC_DEFS_SVH
`define DPMC_DEFS_SVH

`define DPMC_ADDR_W 16
`define DPMC_DATA_W 8
`define DPMC_ADDR_MODE 16'h2105
`define DPMC_ADDR_IRQ_STAT 16'h2110
`define DPMC_ADDR_IRQ_CLR 16'h2111
`define DPMC_ADDR_IRQ_EN 16'h2112
`define DPMC_ADDR_CHAN_STAT 16'h2113

`define DPMC_MODE_RST 8'h00
`define DPMC_BYTE_ZERO 8'h00
`define DPMC_STEP_FLT_BIT 7
`define DPMC_PROF_MSB 6
`define DPMC_PROF_LSB 4
`define DPMC_SEL_MSB 3
`define DPMC_SEL_LSB 2

`define DPMC_PROF_W 3
`define DPMC_PROF_ZERO 3'h0
`define DPMC_PROF_MAX 3'h4
`define DPMC_NUM_PROF 5
`define DPMC_VALID_PAD 3'h0
`define DPMC_PRI_W 4
`define DPMC_PRI_ZERO 4'h0

`define DPMC_SEL_AUTO 2'h0
`define DPMC_SEL_MAN_AUTO 2'h1
`define DPMC_SEL_MAN_HOLD 2'h2
`define DPMC_SEL_USER 2'h3

`define DPMC_EV_W 5
`define DPMC_EV_ZERO 5'h00
`define DPMC_EV_STEP 0
`define DPMC_EV_HOLD 1
`define DPMC_EV_FREE 2
`define DPMC_EV_LOST 3
`define DPMC_EV_PROF 4

`endif

// ### hw/dpmc_pkg.sv
// types shared by the profile mode control modules
package dpmc_pkg;
    typedef enum logic [2:0] {
        ST_SELECT,
        ST_TRACK,
        ST_HOLDOVER,
        ST_FREERUN,
        ST_REVAL,
        ST_USER
    } dpmc_state_type;

    typedef logic [2:0] dpmc_prof_type;
endpackage : dpmc_pkg

// ### hw/dpmc_irq_if.sv
// carrier between the control core and its interrupt registers
`timescale 1ns/1ps
`include "dpmc_defs.svh"

interface dpmc_irq_if;
    logic [`DPMC_EV_W-1:0] events;
    logic clear_wr;
    logic enable_wr;
    logic [`DPMC_EV_W-1:0] wdata;
    logic [`DPMC_EV_W-1:0] status;
    logic [`DPMC_EV_W-1:0] enable;
    logic irq;

    modport ctl (output events, clear_wr, enable_wr, wdata,
                 input status, enable, irq);
    modport regs (input events, clear_wr, enable_wr, wdata,
                  output status, enable, irq);
endinterface : dpmc_irq_if

// ### hw/dpmc_prio_cmp.sv
// one stage of the priority chain: keeps the better of two candidates
`timescale 1ns/1ps
`include "dpmc_defs.svh"

module dpmc_prio_cmp
    import dpmc_pkg::*;
#(
    parameter dpmc_prof_type IDX = `DPMC_PROF_ZERO
)
(
    // best so far
    input wire logic in_valid_in,
    input wire dpmc_prof_type in_idx_in,
    input wire logic [`DPMC_PRI_W-1:0] in_pri_in,
    // candidate of this stage
    input wire logic cand_valid_in,
    input wire logic [`DPMC_PRI_W-1:0] cand_pri_in,
    // best after this stage
    output logic out_valid_out,
    output dpmc_prof_type out_idx_out,
    output logic [`DPMC_PRI_W-1:0] out_pri_out
);
    logic take;

    // strict compare: an equal priority keeps the lower number
    assign take = cand_valid_in && (!in_valid_in || cand_pri_in < in_pri_in);
    assign out_valid_out = in_valid_in || cand_valid_in;
    assign out_idx_out = take ? IDX : in_idx_in;
    assign out_pri_out = take ? cand_pri_in : in_pri_in;
endmodule : dpmc_prio_cmp

// ### hw/dpmc_irq_regs.sv
// sticky event status, enable mask and level interrupt
`timescale 1ns/1ps
`include "dpmc_defs.svh"

module dpmc_irq_regs
    import dpmc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // core side
    dpmc_irq_if.regs bus
);
    logic [`DPMC_EV_W-1:0] status_q;
    logic [`DPMC_EV_W-1:0] status_d;
    logic [`DPMC_EV_W-1:0] enable_q;
    logic irq_q;

    // an event in the clearing cycle survives the clear
    assign status_d = (status_q & ~(bus.clear_wr ? bus.wdata : `DPMC_EV_ZERO))
                      | bus.events;

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            status_q <= `DPMC_EV_ZERO;
        else
            status_q <= status_d;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            enable_q <= `DPMC_EV_ZERO;
        else if (bus.enable_wr)
            enable_q <= bus.wdata;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            irq_q <= 1'b0;
        else
            irq_q <= |(status_d & enable_q);
    end

    assign bus.status = status_q;
    assign bus.enable = enable_q;
    assign bus.irq = irq_q;
endmodule : dpmc_irq_regs

// ### hw/dpmc_top.sv
// profile selection and step detect control for loop channel zero
// Operation
// - step without fault bit: drop edge, reacquire
// - step with fault bit: also reset monitor, revalidate
// - field 6:4 picks manual profile 0 to 4
// - mode 0: highest priority valid profile
// - no profile: holdover with history, else freerun
// - priority tie goes to lowest profile number
// - mode 1: manual, then automatic once invalid
// - mode 2: manual, then holdover once invalid
// - holdover without history uses freerun word
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "dpmc_defs.svh"

module dpmc_top
    import dpmc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // register port
    input wire logic [`DPMC_ADDR_W-1:0] addr_in,
    input wire logic [`DPMC_DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [`DPMC_DATA_W-1:0] rdata_out,
    // loop state inputs
    input wire logic [`DPMC_NUM_PROF-1:0] prof_valid_in,
    input wire logic [`DPMC_NUM_PROF*`DPMC_PRI_W-1:0] prof_priority_in,
    input wire logic history_avail_in,
    input wire logic step_detect_in,
    input wire logic ref_valid_in,
    // loop control outputs
    output dpmc_prof_type active_prof_out,
    output logic prof_locked_out,
    output logic holdover_out,
    output logic freerun_out,
    output logic freerun_word_out,
    output logic user_control_out,
    output logic drop_edge_out,
    output logic acq_restart_out,
    output logic ref_mon_reset_out,
    // interrupt
    output logic irq_out
);
    dpmc_irq_if irq_bus ();

    logic [`DPMC_DATA_W-1:0] mode_q;
    logic [`DPMC_DATA_W-1:0] rdata_q;
    dpmc_state_type state_q;
    dpmc_state_type state_d;
    dpmc_prof_type prof_q;
    dpmc_prof_type prof_d;
    logic lost_q;
    logic lost_set;
    logic step_take;
    logic reval_done;
    logic decide_en;
    logic locked_q;
    logic holdover_q;
    logic freerun_q;
    logic fr_word_q;
    logic user_q;
    logic drop_q;
    logic restart_q;
    logic mon_reset_q;
    logic mode_wr;

    logic fault_en;
    dpmc_prof_type manual_code;
    logic [1:0] sel_mode;
    logic [7:0] valid_ext;
    logic manual_ok;

    logic [`DPMC_NUM_PROF:0] ch_valid;
    dpmc_prof_type ch_idx [0:`DPMC_NUM_PROF];
    logic [`DPMC_PRI_W-1:0] ch_pri [0:`DPMC_NUM_PROF];
    logic best_valid;
    dpmc_prof_type best_idx;
    logic [`DPMC_PRI_W-1:0] best_pri;
    logic [`DPMC_EV_W-1:0] events;

    assign fault_en = mode_q[`DPMC_STEP_FLT_BIT];
    assign manual_code = mode_q[`DPMC_PROF_MSB:`DPMC_PROF_LSB];
    assign sel_mode = mode_q[`DPMC_SEL_MSB:`DPMC_SEL_LSB];
    assign valid_ext = {`DPMC_VALID_PAD, prof_valid_in};
    // undefined codes never qualify
    assign manual_ok = (manual_code <= `DPMC_PROF_MAX)
                       && valid_ext[manual_code];
    assign mode_wr = wr_in && (addr_in == `DPMC_ADDR_MODE);

    // priority chain, lower value wins; ties keep the lower index
    assign ch_valid[0] = 1'b0;
    assign ch_idx[0] = `DPMC_PROF_ZERO;
    assign ch_pri[0] = `DPMC_PRI_ZERO;

    genvar g;
    generate
        for (g = 0; g < `DPMC_NUM_PROF; g++)
        begin : g_prio
            dpmc_prio_cmp #(
                .IDX(3'(g))
            ) u_cmp (
                .in_valid_in(ch_valid[g]),
                .in_idx_in(ch_idx[g]),
                .in_pri_in(ch_pri[g]),
                .cand_valid_in(prof_valid_in[g]),
                .cand_pri_in(prof_priority_in[g*`DPMC_PRI_W +: `DPMC_PRI_W]),
                .out_valid_out(ch_valid[g+1]),
                .out_idx_out(ch_idx[g+1]),
                .out_pri_out(ch_pri[g+1])
            );
        end
    endgenerate

    assign best_valid = ch_valid[`DPMC_NUM_PROF];
    assign best_idx = ch_idx[`DPMC_NUM_PROF];
    assign best_pri = ch_pri[`DPMC_NUM_PROF];

    // a step only matters while the loop is tracking a reference
    assign step_take = (state_q == ST_TRACK) && step_detect_in
                       && (sel_mode != `DPMC_SEL_USER);
    assign reval_done = (state_q == ST_REVAL) && ref_valid_in
                        && (sel_mode != `DPMC_SEL_USER);
    assign decide_en = (state_q == ST_SELECT || state_q == ST_TRACK
                        || state_q == ST_HOLDOVER || state_q == ST_FREERUN)
                       && !step_take && (sel_mode != `DPMC_SEL_USER);

    always_comb
    begin
        state_d = state_q;
        prof_d = prof_q;
        lost_set = 1'b0;
        case (state_q)
            ST_REVAL:
            begin
                // acquisition waits until the monitor qualifies again
                if (sel_mode == `DPMC_SEL_USER)
                    state_d = ST_USER;
                else if (ref_valid_in)
                    state_d = ST_SELECT;
            end
            ST_USER:
            begin
                if (sel_mode != `DPMC_SEL_USER)
                    state_d = ST_SELECT;
            end
            default:
            begin
                if (sel_mode == `DPMC_SEL_USER)
                    state_d = ST_USER;
                else if (step_take)
                    state_d = fault_en ? ST_REVAL : ST_SELECT;
                else if ((sel_mode == `DPMC_SEL_MAN_AUTO
                          || sel_mode == `DPMC_SEL_MAN_HOLD)
                         && manual_ok && !lost_q)
                begin
                    state_d = ST_TRACK;
                    prof_d = manual_code;
                end
                else if (sel_mode == `DPMC_SEL_MAN_HOLD)
                begin
                    state_d = ST_HOLDOVER;
                end
                else if (best_valid)
                begin
                    state_d = ST_TRACK;
                    prof_d = best_idx;
                end
                else
                begin
                    state_d = history_avail_in ? ST_HOLDOVER
                                               : ST_FREERUN;
                end
                // the manual profile is lost once it was in use
                if (decide_en && sel_mode != `DPMC_SEL_AUTO && !lost_q
                    && state_q == ST_TRACK && prof_q == manual_code
                    && !manual_ok)
                    lost_set = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state_q <= ST_SELECT;
            prof_q <= `DPMC_PROF_ZERO;
        end
        else
        begin
            state_q <= state_d;
            prof_q <= prof_d;
        end
    end

    // a new mode write rearms the manual profile
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            lost_q <= 1'b0;
        else if (lost_set)
            lost_q <= 1'b1;
        else if (mode_wr)
            lost_q <= 1'b0;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            locked_q <= 1'b0;
            holdover_q <= 1'b0;
            freerun_q <= 1'b0;
            fr_word_q <= 1'b0;
            user_q <= 1'b0;
        end
        else
        begin
            locked_q <= state_d == ST_TRACK;
            holdover_q <= state_d == ST_HOLDOVER;
            freerun_q <= state_d == ST_FREERUN;
            fr_word_q <= (state_d == ST_FREERUN)
                         || (state_d == ST_HOLDOVER && !history_avail_in);
            user_q <= state_d == ST_USER;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            drop_q <= 1'b0;
            restart_q <= 1'b0;
            mon_reset_q <= 1'b0;
        end
        else
        begin
            drop_q <= step_take;
            restart_q <= (step_take && !fault_en) || reval_done;
            mon_reset_q <= step_take && fault_en;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            mode_q <= `DPMC_MODE_RST;
        else if (mode_wr)
            mode_q <= wdata_in;
    end

    // read data stand for one cycle only; unmapped reads give zero
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            rdata_q <= `DPMC_BYTE_ZERO;
        else if (!rd_in)
            rdata_q <= `DPMC_BYTE_ZERO;
        else
        begin
            case (addr_in)
                `DPMC_ADDR_MODE: rdata_q <= mode_q;
                `DPMC_ADDR_IRQ_STAT: rdata_q <= 8'(irq_bus.status);
                `DPMC_ADDR_IRQ_EN: rdata_q <= 8'(irq_bus.enable);
                `DPMC_ADDR_CHAN_STAT:
                    rdata_q <= {state_q, prof_q, lost_q, fr_word_q};
                default: rdata_q <= `DPMC_BYTE_ZERO;
            endcase
        end
    end

    always_comb
    begin
        events = `DPMC_EV_ZERO;
        events[`DPMC_EV_STEP] = step_take;
        events[`DPMC_EV_HOLD] = state_d == ST_HOLDOVER
                                && state_q != ST_HOLDOVER;
        events[`DPMC_EV_FREE] = state_d == ST_FREERUN
                                && state_q != ST_FREERUN;
        events[`DPMC_EV_LOST] = lost_set;
        events[`DPMC_EV_PROF] = state_d == ST_TRACK
                                && (state_q != ST_TRACK || prof_d != prof_q);
    end

    assign irq_bus.events = events;
    assign irq_bus.clear_wr = wr_in && (addr_in == `DPMC_ADDR_IRQ_CLR);
    assign irq_bus.enable_wr = wr_in && (addr_in == `DPMC_ADDR_IRQ_EN);
    assign irq_bus.wdata = wdata_in[`DPMC_EV_W-1:0];

    dpmc_irq_regs u_irq (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .bus(irq_bus)
    );

    assign rdata_out = rdata_q;
    assign active_prof_out = prof_q;
    assign prof_locked_out = locked_q;
    assign holdover_out = holdover_q;
    assign freerun_out = freerun_q;
    assign freerun_word_out = fr_word_q;
    assign user_control_out = user_q;
    assign drop_edge_out = drop_q;
    assign acq_restart_out = restart_q;
    assign ref_mon_reset_out = mon_reset_q;
    assign irq_out = irq_bus.irq;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_step_plain: assert property (
        step_take && !fault_en |=> drop_edge_out && acq_restart_out
                                   && !ref_mon_reset_out
                                   && state_q == ST_SELECT)
        else $error("plain step did not drop edge and reacquire");

    a_step_fault: assert property (
        step_take && fault_en |=> ref_mon_reset_out && drop_edge_out
                                  && !acq_restart_out
                                  && state_q == ST_REVAL)
        else $error("fault step did not reset the monitor");

    a_reval_hold: assert property (
        state_q == ST_REVAL && !ref_valid_in |=> !acq_restart_out)
        else $error("acquisition restarted before revalidation");

    a_manual_pick: assert property (
        decide_en && sel_mode == `DPMC_SEL_MAN_AUTO && manual_ok && !lost_q
        |=> prof_locked_out && active_prof_out == $past(manual_code))
        else $error("manual profile not applied");

    a_auto_pick: assert property (
        decide_en && sel_mode == `DPMC_SEL_AUTO && best_valid
        |=> prof_locked_out && active_prof_out == $past(best_idx))
        else $error("automatic profile not applied");

    a_auto_empty: assert property (
        decide_en && sel_mode == `DPMC_SEL_AUTO && !best_valid
        |=> holdover_out == $past(history_avail_in)
            && freerun_out == !$past(history_avail_in))
        else $error("wrong fallback with no profile");

    a_tie_low: assert property (
        best_valid && prof_valid_in[0]
        && prof_priority_in[`DPMC_PRI_W-1:0] <= best_pri
        |-> best_idx == `DPMC_PROF_ZERO)
        else $error("tie not resolved to lowest profile");

    a_fall_auto: assert property (
        decide_en && sel_mode == `DPMC_SEL_MAN_AUTO && !manual_ok && best_valid
        |=> active_prof_out == $past(best_idx) && prof_locked_out)
        else $error("manual loss did not fall back to automatic");

    a_fall_hold: assert property (
        decide_en && sel_mode == `DPMC_SEL_MAN_HOLD && (!manual_ok || lost_q)
        |=> holdover_out && !prof_locked_out)
        else $error("manual loss did not enter holdover");

    a_user_idle: assert property (
        sel_mode == `DPMC_SEL_USER && state_q != ST_REVAL
        |=> user_control_out && !prof_locked_out ##1 !acq_restart_out)
        else $error("device acted in user control mode");

    a_hold_word: assert property (
        $rose(holdover_out) |-> freerun_word_out == !$past(history_avail_in))
        else $error("holdover tuning word source wrong");

    a_bad_code: assert property (
        decide_en && sel_mode == `DPMC_SEL_MAN_HOLD
        && manual_code > `DPMC_PROF_MAX |=> holdover_out)
        else $error("undefined profile code treated as valid");

    c_fault_step: cover property (step_take && fault_en ##[1:20] reval_done);
    c_manual_lost: cover property (lost_set ##1 holdover_out);
    c_auto_track: cover property (sel_mode == `DPMC_SEL_AUTO
                                  ##1 prof_locked_out);
endmodule : dpmc_top

// ### verification/dpmc_tb.sv
// self-checking bench for the profile mode control top
`timescale 1ns/1ps
`include "dpmc_defs.svh"

module testbench
    import dpmc_pkg::*;
;
    typedef struct {
        logic [7:0] mode;
        logic [4:0] valid;
        logic [19:0] prio;
        logic hist;
        logic [2:0] prof;
        logic [4:0] flags;
    } dpmc_tb_row_type;

    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [15:0] addr_in = 16'h0000;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] rdata_out;
    logic [4:0] prof_valid_in = 5'h00;
    logic [19:0] prof_priority_in = 20'h0_0000;
    logic history_avail_in = 1'b0;
    logic step_detect_in = 1'b0;
    logic ref_valid_in = 1'b1;
    dpmc_prof_type active_prof_out;
    logic prof_locked_out;
    logic holdover_out;
    logic freerun_out;
    logic freerun_word_out;
    logic user_control_out;
    logic drop_edge_out;
    logic acq_restart_out;
    logic ref_mon_reset_out;
    logic irq_out;
    logic [4:0] flags;
    logic [7:0] rd_val;
    int failures = 0;
    int comparisons = 0;
    dpmc_tb_row_type rows [12];

    assign flags = {prof_locked_out, holdover_out, freerun_out,
                    freerun_word_out, user_control_out};

    dpmc_top dpmc_top_inst (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .addr_in(addr_in),
        .wdata_in(wdata_in),
        .wr_in(wr_in),
        .rd_in(rd_in),
        .rdata_out(rdata_out),
        .prof_valid_in(prof_valid_in),
        .prof_priority_in(prof_priority_in),
        .history_avail_in(history_avail_in),
        .step_detect_in(step_detect_in),
        .ref_valid_in(ref_valid_in),
        .active_prof_out(active_prof_out),
        .prof_locked_out(prof_locked_out),
        .holdover_out(holdover_out),
        .freerun_out(freerun_out),
        .freerun_word_out(freerun_word_out),
        .user_control_out(user_control_out),
        .drop_edge_out(drop_edge_out),
        .acq_restart_out(acq_restart_out),
        .ref_mon_reset_out(ref_mon_reset_out),
        .irq_out(irq_out)
    );

    initial
    begin
        forever #2.5 clk_in = ~clk_in;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : reg_write

    // read data stand only in the cycle after the strobe edge
    task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        d = rdata_out;
    endtask : reg_read

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : wait_cyc

    task automatic pulse_step();
        @(posedge clk_in);
        step_detect_in <= 1'b1;
        @(posedge clk_in);
        step_detect_in <= 1'b0;
        #1;
    endtask : pulse_step

    task automatic set_loop(input logic [4:0] v, input logic [19:0] p,
                            input logic h);
        @(posedge clk_in);
        prof_valid_in <= v;
        prof_priority_in <= p;
        history_avail_in <= h;
    endtask : set_loop

    initial
    begin
        repeat (5000) @(posedge clk_in);
        failures++;
        print_verdict();
    end

    initial
    begin
        rows = '{
            '{8'h00, 5'h1F, 20'h5_1555, 1'b1, 3'h3, 5'h10},
            '{8'h00, 5'h16, 20'h2_2222, 1'b1, 3'h1, 5'h10},
            '{8'h00, 5'h00, 20'h2_2222, 1'b1, 3'h1, 5'h08},
            '{8'h00, 5'h00, 20'h2_2222, 1'b0, 3'h1, 5'h06},
            '{8'h24, 5'h1F, 20'h5_5550, 1'b1, 3'h2, 5'h10},
            '{8'h24, 5'h1B, 20'h5_5550, 1'b1, 3'h0, 5'h10},
            '{8'h48, 5'h1F, 20'h5_5550, 1'b1, 3'h4, 5'h10},
            '{8'h38, 5'h17, 20'h5_5550, 1'b1, 3'h4, 5'h08},
            '{8'h38, 5'h17, 20'h5_5550, 1'b0, 3'h4, 5'h0A},
            '{8'h54, 5'h1F, 20'h5_5550, 1'b1, 3'h0, 5'h10},
            '{8'h78, 5'h1F, 20'h5_5550, 1'b1, 3'h0, 5'h08},
            '{8'h0C, 5'h1F, 20'h5_5550, 1'b1, 3'h0, 5'h01}
        };
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'b1;
        // register table and bus behaviour
        reg_read(`DPMC_ADDR_MODE, rd_val);
        check(rd_val, 8'h00);
        wait_cyc(1);
        check(rdata_out, 8'h00);
        reg_write(`DPMC_ADDR_MODE, 8'hA7);
        reg_read(`DPMC_ADDR_MODE, rd_val);
        check(rd_val, 8'hA7);
        reg_read(16'h2106, rd_val);
        check(rd_val, 8'h00);
        reg_write(`DPMC_ADDR_IRQ_EN, 8'hFF);
        reg_read(`DPMC_ADDR_IRQ_EN, rd_val);
        check(rd_val, 8'h1F);
        reg_write(`DPMC_ADDR_IRQ_EN, 8'h00);
        // ordinary selection cases, one row each
        for (int i = 0; i < 12; i++)
        begin
            set_loop(rows[i].valid, rows[i].prio, rows[i].hist);
            reg_write(`DPMC_ADDR_MODE, rows[i].mode);
            wait_cyc(4);
            check({5'h00, active_prof_out}, {5'h00, rows[i].prof});
            check({3'h0, flags}, {3'h0, rows[i].flags});
        end
        // every manual code that names a profile
        set_loop(5'h1F, 20'h5_5555, 1'b1);
        for (int c = 0; c < 5; c++)
        begin
            reg_write(`DPMC_ADDR_MODE, {1'b0, c[2:0], 2'b01, 2'b00});
            wait_cyc(4);
            check({5'h00, active_prof_out}, {5'h00, c[2:0]});
        end
        // step without monitor reset, interrupt enabled
        set_loop(5'h1F, 20'h5_1555, 1'b1);
        reg_write(`DPMC_ADDR_MODE, 8'h00);
        reg_write(`DPMC_ADDR_IRQ_EN, 8'h1F);
        wait_cyc(4);
        reg_write(`DPMC_ADDR_IRQ_CLR, 8'h1F);
        wait_cyc(3);
        check({7'h00, irq_out}, 8'h00);
        pulse_step();
        check({5'h00, drop_edge_out, acq_restart_out, ref_mon_reset_out},
              8'h06);
        check({7'h00, prof_locked_out}, 8'h00);
        wait_cyc(3);
        check({7'h00, irq_out}, 8'h01);
        check({7'h00, prof_locked_out}, 8'h01);
        reg_read(`DPMC_ADDR_IRQ_STAT, rd_val);
        check(rd_val & 8'h01, 8'h01);
        reg_write(`DPMC_ADDR_IRQ_CLR, 8'h1F);
        wait_cyc(3);
        check({7'h00, irq_out}, 8'h00);
        // masked event still lands in status
        reg_write(`DPMC_ADDR_IRQ_EN, 8'h00);
        pulse_step();
        wait_cyc(4);
        check({7'h00, irq_out}, 8'h00);
        reg_read(`DPMC_ADDR_IRQ_STAT, rd_val);
        check(rd_val & 8'h01, 8'h01);
        // step with monitor reset waits for revalidation
        reg_write(`DPMC_ADDR_MODE, 8'h80);
        wait_cyc(4);
        @(posedge clk_in);
        ref_valid_in <= 1'b0;
        pulse_step();
        check({5'h00, drop_edge_out, acq_restart_out, ref_mon_reset_out},
              8'h05);
        wait_cyc(3);
        check({6'h00, prof_locked_out, acq_restart_out}, 8'h00);
        @(posedge clk_in);
        ref_valid_in <= 1'b1;
        wait_cyc(1);
        check({7'h00, acq_restart_out}, 8'h01);
        wait_cyc(1);
        check({7'h00, acq_restart_out}, 8'h00);
        wait_cyc(3);
        check({7'h00, prof_locked_out}, 8'h01);
        // mode 2: a lost manual profile stays in holdover until rewritten
        reg_write(`DPMC_ADDR_MODE, 8'h18);
        wait_cyc(4);
        check({5'h00, active_prof_out}, 8'h01);
        set_loop(5'h1D, 20'h5_1555, 1'b1);
        wait_cyc(3);
        check({3'h0, flags}, 8'h08);
        set_loop(5'h1F, 20'h5_1555, 1'b1);
        wait_cyc(3);
        check({3'h0, flags}, 8'h08);
        reg_read(`DPMC_ADDR_CHAN_STAT, rd_val);
        check(rd_val, 8'h46);
        reg_write(`DPMC_ADDR_MODE, 8'h18);
        wait_cyc(4);
        check({3'h0, flags}, 8'h10);
        // under user control a step is not acted on
        reg_write(`DPMC_ADDR_MODE, 8'h8C);
        wait_cyc(4);
        pulse_step();
        check({5'h00, drop_edge_out, acq_restart_out, ref_mon_reset_out},
              8'h00);
        check({7'h00, user_control_out}, 8'h01);
        // reset in mid-run clears the mode and every output
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        wait_cyc(2);
        check({3'h0, flags}, 8'h00);
        check({7'h00, irq_out}, 8'h00);
        @(posedge clk_in);
        reset_n_in <= 1'b1;
        reg_read(`DPMC_ADDR_MODE, rd_val);
        check(rd_val, 8'h00);
        wait_cyc(3);
        check({3'h0, flags}, 8'h10);
        print_verdict();
    end
endmodule : testbench
